// >>> hw/tcdt_regs.vh
// Command codes, field positions, reset values and limits of the calibration/dead-time bank
`ifndef TCDT_REGS_VH
`define TCDT_REGS_VH

// Command codes of the bank
`define TCDT_CMD_EXT_SCALE      8'hd9
`define TCDT_CMD_EXT_OFFSET     8'hda
`define TCDT_CMD_SENSE_TC       8'hdc
`define TCDT_CMD_GAP_VALUES     8'hdd
`define TCDT_CMD_GAP_MODE       8'hde

// Reset values
`define TCDT_RST_EXT_SCALE      16'hba00
`define TCDT_RST_EXT_OFFSET     16'h0000
`define TCDT_RST_SENSE_TC       8'h27
`define TCDT_RST_GAP_VALUES     16'h1010
`define TCDT_RST_GAP_MODE       16'h8888

// Linear-11 layout
`define TCDT_L11_EXP_MSB        15
`define TCDT_L11_EXP_LSB        11
`define TCDT_L11_MAN_MSB        10
// Temperature fixed point: 1/16 degree per count
`define TCDT_TEMP_FRAC_BITS     4

// Tempco fields
`define TCDT_TC_SRC_BIT         7
`define TCDT_TC_FACTOR_MSB      6
`define TCDT_TC_FACTOR_MAX      7'h3f
`define TCDT_TC_REF_TEMP        12'h019
`define TCDT_TC_UNITY           24'h00_2710

// Dead-time mode fields: frozen bit and minimum field per byte lane
`define TCDT_GAP_FROZEN_BIT     7
`define TCDT_GAP_MIN_MSB        6
// Supported dead-time range in ns (10-bit signed)
`define TCDT_GAP_NS_LOW         10'h3f1
`define TCDT_GAP_NS_HIGH        10'h03c

// Offset limit +-100 degrees in 1/16 degree counts
`define TCDT_OFFSET_LIMIT       32'h0000_0640
// Divider iterations
`define TCDT_DIV_STEPS          6'h20
`endif

// >>> hw/tcdt_lin11_fix.v
// Linear-11 to signed fixed point (1/16 degree) converter
`timescale 1ns/10ps
`include "tcdt_regs.vh"

module tcdt_lin11_fix (
  input  wire [15:0] i_lin,
  output reg  [31:0] o_fix
);

  reg signed [31:0] man_ext;
  reg signed [5:0]  shift_amt;
  reg        [5:0]  shift_mag;

  // Mantissa times two to the exponent, pre-scaled by the fraction bits
  always @* begin
    man_ext   = {{21{i_lin[`TCDT_L11_MAN_MSB]}}, i_lin[`TCDT_L11_MAN_MSB:0]};
    shift_amt = {i_lin[`TCDT_L11_EXP_MSB], i_lin[`TCDT_L11_EXP_MSB:`TCDT_L11_EXP_LSB]}
                + 6'sd4;
    shift_mag = shift_amt[5] ? (~shift_amt + 6'd1) : shift_amt;
    if (shift_amt[5]) begin
      o_fix = man_ext >>> shift_mag;
    end else begin
      o_fix = man_ext <<< shift_mag;
    end
  end

endmodule // tcdt_lin11_fix

// >>> hw/tcdt_divider.v
// Sequential signed divider, one quotient bit per cycle
`timescale 1ns/10ps
`include "tcdt_regs.vh"

module tcdt_divider (
  input  wire        i_sys_clk,
  input  wire        i_rst_b,
  input  wire        i_start,
  input  wire [31:0] i_dividend,
  input  wire [10:0] i_divisor,
  output reg         o_done,
  output reg         o_div_zero,
  output reg  [31:0] o_quot
);

  reg [31:0] quot_q;
  reg [10:0] rem_q;
  reg [10:0] dmag_q;
  reg        neg_q;
  reg [5:0]  cnt_q;
  reg        busy_q;
  reg [11:0] rem_sh;

  // Shifted remainder for the trial subtraction
  always @* begin
    rem_sh = {rem_q, quot_q[31]};
  end

  // Restoring division on magnitudes; sign is fixed at the end
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      quot_q     <= 32'h0000_0000;
      rem_q      <= 11'h000;
      dmag_q     <= 11'h000;
      neg_q      <= 1'b0;
      cnt_q      <= 6'h00;
      busy_q     <= 1'b0;
      o_done     <= 1'b0;
      o_div_zero <= 1'b0;
      o_quot     <= 32'h0000_0000;
    end else begin
      o_done <= 1'b0;
      if (i_start && !busy_q) begin
        quot_q <= i_dividend[31] ? (~i_dividend + 32'h0000_0001) : i_dividend;
        dmag_q <= i_divisor[10] ? (~i_divisor + 11'h001) : i_divisor;
        neg_q  <= i_dividend[31] ^ i_divisor[10];
        rem_q  <= 11'h000;
        cnt_q  <= `TCDT_DIV_STEPS;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (rem_sh >= {1'b0, dmag_q}) begin
          rem_q <= rem_sh[10:0] - dmag_q;
          quot_q <= {quot_q[30:0], 1'b1};
        end else begin
          rem_q <= rem_sh[10:0];
          quot_q <= {quot_q[30:0], 1'b0};
        end
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          busy_q <= 1'b0;
          o_done <= 1'b1;
        end
      end
      // Final sign and divide-by-zero marking on the last step
      if (busy_q && cnt_q == 6'h01) begin
        o_div_zero <= (dmag_q == 11'h000);
        if (rem_sh >= {1'b0, dmag_q}) begin
          o_quot <= neg_q ? (~{quot_q[30:0], 1'b1} + 32'h0000_0001) : {quot_q[30:0], 1'b1};
        end else begin
          o_quot <= neg_q ? (~{quot_q[30:0], 1'b0} + 32'h0000_0001) : {quot_q[30:0], 1'b0};
        end
      end
    end
  end

endmodule // tcdt_divider

// >>> hw/tcdt_regbank.v
// Calibration, tempco and dead-time configuration bank with its derived outputs
`timescale 1ns/10ps
`include "tcdt_regs.vh"

// Operation
// RQ1: Scale register is 16-bit linear-11, default 1.0, shared by both sensors.
// RQ2: Reported external temperature is measured divided by scale plus offset.
// RQ3: Offset register is linear-11 degrees, resets to zero, limited to +-100.
// RQ4: Tempco top bit picks internal or external sensors; external needs sensing enabled.
// RQ5: Low seven bits give factor per 100 ppm; ratio is one plus factor times T-25.
// RQ6: Correction opposes positive coefficient; same factor for both external sensors.
// RQ7: Tempco default 3900 ppm; usable factor range zero to 6300 ppm.
// RQ8: Dead-time register holds two signed bytes: high byte H-to-L, low L-to-H.
// RQ9: Positive dead time means a gap, negative means on-time overlap.
// RQ10: Dead time defaults to 16 ns each; supported range -15 to 60 ns.
// RQ11: Values write directly before mode write becomes new adaptive upper limit.
// RQ12: With adaptive control off, drive exactly the stored dead-time values; the code clamps them to -15..60 ns.
// RQ13: Bit 15 and bit 7 choose adaptive (0) or frozen (1) per transition.
// RQ14: Bits 14:8 and 6:0 set adaptive minimum dead time in 2 ns steps.
// RQ15: Mode register defaults to frozen, 8 ns minimum on both transitions.
// RQ16: All commands read and write, and writes obey write protection.
// RQ17: Linear-11 value equals signed mantissa times two to signed exponent.
// RQ18: Reset loads every register with its default before any access.
module tcdt_regbank (
  input  wire        i_sys_clk,
  input  wire        i_rst_b,
  input  wire        i_cmd_valid,
  input  wire        i_cmd_write,
  input  wire [7:0]  i_cmd_code,
  input  wire [15:0] i_cmd_wdata,
  input  wire        i_write_protect,
  output wire        o_cmd_done,
  output wire        o_cmd_err,
  output wire [15:0] o_cmd_rdata,
  input  wire        i_ext_sense_en,
  input  wire [15:0] i_int_temp,
  input  wire [15:0] i_ext_temp_a,
  input  wire [15:0] i_ext_temp_b,
  output wire [15:0] o_ext_rpt_a,
  output wire [15:0] o_ext_rpt_b,
  output wire        o_tc_src_ext,
  output wire [23:0] o_rsense_ratio_a,
  output wire [23:0] o_rsense_ratio_b,
  input  wire [9:0]  i_dt_hl_adapt,
  input  wire [9:0]  i_dt_lh_adapt,
  output wire [9:0]  o_dt_hl_ns,
  output wire [9:0]  o_dt_lh_ns,
  output wire        o_dt_hl_frozen,
  output wire        o_dt_lh_frozen,
  output wire [7:0]  o_dt_hl_max,
  output wire [7:0]  o_dt_lh_max,
  output wire [7:0]  o_dt_hl_min,
  output wire [7:0]  o_dt_lh_min
);

  // Sequencer states for the shared divider
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_BUSY = 2'b10;

  reg  [15:0] ext_temp_scale_q;
  reg  [15:0] ext_temp_offset_q;
  reg  [7:0]  sense_tc_correction_q;
  reg  [15:0] switch_gap_values_q;
  reg  [15:0] switch_gap_mode_q;
  reg  [15:0] gap_max_q;
  reg         values_last_q;
  reg         cmd_done_q;
  reg         cmd_err_q;
  reg  [15:0] cmd_rdata_q;
  reg  [1:0]  state_q;
  reg         sel_b_q;
  reg         div_start_q;
  reg  [31:0] dividend_q;
  reg  [15:0] ext_rpt_a_q;
  reg  [15:0] ext_rpt_b_q;
  reg         tc_src_ext_q;
  reg  [31:0] temp_shift;
  reg  [4:0]  exp_mag;
  reg  [15:0] quot_sat;
  reg  [31:0] offset_sat;
  reg  [31:0] rpt_sum;
  reg  [15:0] rpt_sat;
  reg  [6:0]  tc_use;
  wire        div_done;
  wire        div_zero;
  wire [31:0] div_quot;
  wire [31:0] offset_fix;
  wire [19:0] dt_adapt;
  wire [31:0] ext_temp_pair;
  wire        write_ok;

  assign write_ok      = i_cmd_valid && i_cmd_write && !i_write_protect;
  assign dt_adapt      = {i_dt_hl_adapt, i_dt_lh_adapt};
  assign ext_temp_pair = {i_ext_temp_b, i_ext_temp_a};

  // Command port: one access per valid, answered the next cycle
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      // RQ18 defaults at reset
      ext_temp_scale_q      <= `TCDT_RST_EXT_SCALE;
      ext_temp_offset_q     <= `TCDT_RST_EXT_OFFSET;
      sense_tc_correction_q <= `TCDT_RST_SENSE_TC;
      switch_gap_values_q   <= `TCDT_RST_GAP_VALUES;
      switch_gap_mode_q     <= `TCDT_RST_GAP_MODE;
      gap_max_q             <= `TCDT_RST_GAP_VALUES;
      values_last_q         <= 1'b0;
      cmd_done_q            <= 1'b0;
      cmd_err_q             <= 1'b0;
      cmd_rdata_q           <= 16'h0000;
    end else begin
      cmd_done_q <= i_cmd_valid;
      cmd_err_q  <= 1'b0;
      if (i_cmd_valid) begin
        // Any command other than an accepted values write breaks the pairing
        values_last_q <= 1'b0;
        // RQ16 protected writes refused
        if (i_cmd_write && i_write_protect) begin
          cmd_err_q <= 1'b1;
        end
        case (i_cmd_code)
          `TCDT_CMD_EXT_SCALE: begin
            cmd_rdata_q <= ext_temp_scale_q;
            if (write_ok) begin
              ext_temp_scale_q <= i_cmd_wdata;
            end
          end
          `TCDT_CMD_EXT_OFFSET: begin
            cmd_rdata_q <= ext_temp_offset_q;
            if (write_ok) begin
              ext_temp_offset_q <= i_cmd_wdata;
            end
          end
          `TCDT_CMD_SENSE_TC: begin
            // Narrow register reads with zero upper byte
            cmd_rdata_q <= {8'h00, sense_tc_correction_q};
            if (write_ok) begin
              sense_tc_correction_q <= i_cmd_wdata[7:0];
            end
          end
          `TCDT_CMD_GAP_VALUES: begin
            cmd_rdata_q <= switch_gap_values_q;
            if (write_ok) begin
              switch_gap_values_q <= i_cmd_wdata;
              values_last_q       <= 1'b1;
            end
          end
          `TCDT_CMD_GAP_MODE: begin
            cmd_rdata_q <= switch_gap_mode_q;
            if (write_ok) begin
              switch_gap_mode_q <= i_cmd_wdata;
              // RQ11 latch new upper limit
              if (values_last_q) begin
                gap_max_q <= switch_gap_values_q;
              end
            end
          end
          default: begin
            // Unknown codes answer zero with an error
            cmd_rdata_q <= 16'h0000;
            cmd_err_q   <= 1'b1;
          end
        endcase
      end
    end
  end

  // Offset conversion from linear-11 to 1/16 degree
  // RQ17 offset decoding
  tcdt_lin11_fix u_offset_fix (
    .i_lin (ext_temp_offset_q),
    .o_fix (offset_fix)
  );

  // Dividend: temperature pre-shifted by the negated scale exponent
  always @* begin
    exp_mag = ext_temp_scale_q[15] ? (~ext_temp_scale_q[15:11] + 5'h01)
                                   : ext_temp_scale_q[15:11];
    temp_shift = sel_b_q ? {{16{ext_temp_pair[31]}}, ext_temp_pair[31:16]}
                         : {{16{ext_temp_pair[15]}}, ext_temp_pair[15:0]};
    // RQ1 scale exponent applied
    if (ext_temp_scale_q[15]) begin
      temp_shift = temp_shift << exp_mag;
    end else begin
      temp_shift = $signed(temp_shift) >>> exp_mag;
    end
  end

  // Shared divider: one sensor at a time keeps the area down at the cost of latency
  tcdt_divider u_div (
    .i_sys_clk  (i_sys_clk),
    .i_rst_b    (i_rst_b),
    .i_start    (div_start_q),
    .i_dividend (dividend_q),
    .i_divisor  (ext_temp_scale_q[10:0]),
    .o_done     (div_done),
    .o_div_zero (div_zero),
    .o_quot     (div_quot)
  );

  // Saturate quotient and offset, then add and saturate again
  always @* begin
    if (div_zero) begin
      quot_sat = 16'h7fff;
    end else if (!div_quot[31] && div_quot[30:15] != 16'h0000) begin
      quot_sat = 16'h7fff;
    end else if (div_quot[31] && div_quot[30:15] != 16'hffff) begin
      quot_sat = 16'h8000;
    end else begin
      quot_sat = div_quot[15:0];
    end
    // RQ3 offset limited to +-100 degrees
    if ($signed(offset_fix) > $signed(`TCDT_OFFSET_LIMIT)) begin
      offset_sat = `TCDT_OFFSET_LIMIT;
    end else if ($signed(offset_fix) < -$signed(`TCDT_OFFSET_LIMIT)) begin
      offset_sat = ~`TCDT_OFFSET_LIMIT + 32'h0000_0001;
    end else begin
      offset_sat = offset_fix;
    end
    rpt_sum = {{16{quot_sat[15]}}, quot_sat} + offset_sat;
    if ($signed(rpt_sum) > $signed(32'h0000_7fff)) begin
      rpt_sat = 16'h7fff;
    end else if ($signed(rpt_sum) < $signed(32'hffff_8000)) begin
      rpt_sat = 16'h8000;
    end else begin
      rpt_sat = rpt_sum[15:0];
    end
  end

  // Sequencer alternating the two external readings through the divider
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      state_q     <= ST_IDLE;
      sel_b_q     <= 1'b0;
      div_start_q <= 1'b0;
      dividend_q  <= 32'h0000_0000;
      ext_rpt_a_q <= 16'h0000;
      ext_rpt_b_q <= 16'h0000;
    end else begin
      div_start_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          dividend_q  <= temp_shift;
          div_start_q <= 1'b1;
          state_q     <= ST_BUSY;
        end
        ST_BUSY: begin
          if (div_done) begin
            // RQ2 scaled reading plus offset
            if (sel_b_q) begin
              ext_rpt_b_q <= rpt_sat;
            end else begin
              ext_rpt_a_q <= rpt_sat;
            end
            sel_b_q <= ~sel_b_q;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Tempco factor limited to its usable range
  always @* begin
    // RQ7 factor capped at 6300 ppm
    if (sense_tc_correction_q[`TCDT_TC_FACTOR_MSB:0] > `TCDT_TC_FACTOR_MAX) begin
      tc_use = `TCDT_TC_FACTOR_MAX;
    end else begin
      tc_use = sense_tc_correction_q[`TCDT_TC_FACTOR_MSB:0];
    end
  end

  // Source select; external falls back to internal when sensing is off
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      tc_src_ext_q <= 1'b0;
    end else begin
      // RQ4 source selection
      tc_src_ext_q <= sense_tc_correction_q[`TCDT_TC_SRC_BIT] && i_ext_sense_en;
    end
  end

  // Sense ratio per phase, in 100 ppm counts where unity is 10000
  genvar gs;
  generate
    for (gs = 0; gs < 2; gs = gs + 1) begin : g_tc
      reg  [23:0] ratio_q;
      wire [15:0] temp_raw;
      wire [11:0] temp_deg;
      wire [11:0] temp_rel;
      wire [23:0] prod;
      assign temp_raw = tc_src_ext_q ? ext_temp_pair[gs*16 +: 16] : i_int_temp;
      assign temp_deg = temp_raw[15:`TCDT_TEMP_FRAC_BITS];
      assign temp_rel = temp_deg - `TCDT_TC_REF_TEMP;
      assign prod     = $signed({{12{temp_rel[11]}}, temp_rel}) * $signed({17'h0_0000, tc_use});
      always @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
          ratio_q <= `TCDT_TC_UNITY;
        end else begin
          // RQ5 one plus factor times T-25
          // RQ6 same factor on both phases
          ratio_q <= `TCDT_TC_UNITY + prod;
        end
      end
    end
  endgenerate

  // Per-transition dead time: lane 1 is H-to-L, lane 0 is L-to-H
  genvar gd;
  generate
    for (gd = 0; gd < 2; gd = gd + 1) begin : g_dt
      reg  [9:0] ns_q;
      reg  [9:0] pick;
      wire [9:0] stored;
      wire [9:0] upper;
      wire [9:0] lower;
      wire [9:0] adapt;
      wire       frozen;
      // RQ8 signed byte per transition
      assign stored = {{2{switch_gap_values_q[gd*8+7]}}, switch_gap_values_q[gd*8 +: 8]};
      assign upper  = {{2{gap_max_q[gd*8+7]}}, gap_max_q[gd*8 +: 8]};
      // RQ14 minimum in ns on a 2 ns grid; bit 0 of the field is ignored
      assign lower  = {3'b000, switch_gap_mode_q[gd*8+1 +: 6], 1'b0};
      // RQ13 frozen bit per lane
      assign frozen = switch_gap_mode_q[gd*8+`TCDT_GAP_FROZEN_BIT];
      assign adapt  = dt_adapt[gd*10 +: 10];
      always @* begin
        // RQ12 frozen drives the stored value
        if (frozen) begin
          pick = stored;
        end else if ($signed(adapt) > $signed(upper)) begin
          pick = upper;
        end else if ($signed(adapt) < $signed(lower)) begin
          pick = lower;
        end else begin
          pick = adapt;
        end
        // RQ10 supported range clamp
        if ($signed(pick) > $signed(`TCDT_GAP_NS_HIGH)) begin
          pick = `TCDT_GAP_NS_HIGH;
        end else if ($signed(pick) < $signed(`TCDT_GAP_NS_LOW)) begin
          pick = `TCDT_GAP_NS_LOW;
        end
      end
      always @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
          ns_q <= 10'h010;
        end else begin
          // RQ9 sign gives gap or overlap downstream
          ns_q <= pick;
        end
      end
    end
  endgenerate

  // Outputs straight from registers
  assign o_cmd_done       = cmd_done_q;
  assign o_cmd_err        = cmd_err_q;
  assign o_cmd_rdata      = cmd_rdata_q;
  assign o_ext_rpt_a      = ext_rpt_a_q;
  assign o_ext_rpt_b      = ext_rpt_b_q;
  assign o_tc_src_ext     = tc_src_ext_q;
  assign o_rsense_ratio_a = g_tc[0].ratio_q;
  assign o_rsense_ratio_b = g_tc[1].ratio_q;
  assign o_dt_hl_ns       = g_dt[1].ns_q;
  assign o_dt_lh_ns       = g_dt[0].ns_q;
  assign o_dt_hl_frozen   = switch_gap_mode_q[15];
  assign o_dt_lh_frozen   = switch_gap_mode_q[7];
  assign o_dt_hl_max      = gap_max_q[15:8];
  assign o_dt_lh_max      = gap_max_q[7:0];
  // Minimum is the field in ns, rounded down to the 2 ns grid
  assign o_dt_hl_min      = {1'b0, switch_gap_mode_q[14:9], 1'b0};
  assign o_dt_lh_min      = {1'b0, switch_gap_mode_q[6:1], 1'b0};

endmodule // tcdt_regbank

// >>> verif/tcdt_regbank_sva.sv
// Concurrent checks on the command port, the dead-time outputs and the tempco source select
`timescale 1ns/10ps
module tcdt_regbank_sva (
  input wire        i_sys_clk,
  input wire        i_rst_b,
  input wire        i_cmd_valid,
  input wire        i_cmd_write,
  input wire [7:0]  i_cmd_code,
  input wire [15:0] i_cmd_wdata,
  input wire        i_write_protect,
  input wire        o_cmd_done,
  input wire        o_cmd_err,
  input wire        i_ext_sense_en,
  input wire        o_tc_src_ext,
  input wire [9:0]  i_dt_hl_adapt,
  input wire [9:0]  o_dt_hl_ns,
  input wire [9:0]  o_dt_lh_ns,
  input wire        o_dt_hl_frozen,
  input wire        o_dt_lh_frozen,
  input wire [7:0]  o_dt_hl_min,
  input wire [7:0]  o_dt_hl_max
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  // Write data of the previous edge, so a slice needs no sampled-value call
  logic        [15:0] wd_q;
  // Signed views of the adaptive request and its limits
  wire signed  [9:0]  ad = i_dt_hl_adapt;
  wire signed  [9:0]  mn = {2'b00, o_dt_hl_min};
  wire signed  [9:0]  mx = {{2{o_dt_hl_max[7]}}, o_dt_hl_max};
  wire                cmd_ok = (i_cmd_code == 8'hd9) || (i_cmd_code == 8'hda) ||
                               (i_cmd_code == 8'hdc) || (i_cmd_code == 8'hdd) ||
                               (i_cmd_code == 8'hde);

  always @(posedge i_sys_clk) begin
    wd_q <= i_cmd_wdata;
  end

  done_follows_a: assert property (i_cmd_valid |=> o_cmd_done)
    else $error("done missing after a request");
  done_caused_a: assert property (o_cmd_done |-> $past(i_cmd_valid))
    else $error("done without a request");
  protect_err_a: assert property (i_cmd_valid && i_cmd_write && i_write_protect |=> o_cmd_err)
    else $error("protected write not refused");
  read_clean_a: assert property (i_cmd_valid && !i_cmd_write && cmd_ok |=> !o_cmd_err)
    else $error("read of a known command refused");
  mode_load_a: assert property (i_cmd_valid && i_cmd_write && !i_write_protect &&
    i_cmd_code == 8'hde |=> o_dt_hl_min == {1'b0, wd_q[14:9], 1'b0} &&
    o_dt_hl_frozen == wd_q[15] && o_dt_lh_frozen == wd_q[7])
    else $error("mode fields not applied");
  gap_range_a: assert property ($signed(o_dt_hl_ns) >= -10'sh00f &&
    $signed(o_dt_hl_ns) <= 10'sh03c && $signed(o_dt_lh_ns) >= -10'sh00f &&
    $signed(o_dt_lh_ns) <= 10'sh03c)
    else $error("dead time outside supported range");
  adapt_pass_a: assert property (!o_dt_hl_frozen && ad >= mn && ad <= mx &&
    ad >= -10'sh00f && ad <= 10'sh03c |=> o_dt_hl_ns == $past(i_dt_hl_adapt))
    else $error("in-range adaptive value not driven");
  src_needs_en_a: assert property (o_tc_src_ext |-> $past(i_ext_sense_en))
    else $error("external source without sensing enabled");

  cover property (i_cmd_valid && i_cmd_write && i_write_protect);
  cover property (!o_dt_hl_frozen && o_dt_hl_ns == mx);
  cover property (o_tc_src_ext);
endmodule // tcdt_regbank_sva

// >>> verif/tcdt_host_model.sv
// Host model that issues single reads and writes on the command port
`timescale 1ns/10ps
module tcdt_host_model (
  input  wire        i_sys_clk,
  input  wire        i_cmd_done,
  input  wire        i_cmd_err,
  input  wire [15:0] i_cmd_rdata,
  output logic       o_cmd_valid,
  output logic       o_cmd_write,
  output logic [7:0] o_cmd_code,
  output logic [15:0] o_cmd_wdata
);
  logic        ok;
  logic        err;
  logic [15:0] rdata;

  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_write = 1'b0;
    o_cmd_code  = 8'h00;
    o_cmd_wdata = 16'h0000;
  end

  // One request for one edge; answer collected with a bounded wait
  task xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd);
    int n;
    @(negedge i_sys_clk);
    o_cmd_valid = 1'b1;
    o_cmd_write = wr;
    o_cmd_code  = code;
    o_cmd_wdata = wd;
    @(negedge i_sys_clk);
    o_cmd_valid = 1'b0;
    // Released data is flipped so a stale value can never look valid
    o_cmd_wdata = ~wd;
    ok = 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      if (i_cmd_done === 1'b1) begin
        ok    = 1'b1;
        err   = i_cmd_err;
        rdata = i_cmd_rdata;
      end else begin
        @(negedge i_sys_clk);
      end
    end
  endtask
endmodule // tcdt_host_model

// >>> verif/tcdt_regbank_bench.sv
// Self-checking bench for the calibration and dead-time bank
`timescale 1ns/10ps
module tcdt_regbank_bench;
  logic        i_sys_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        i_cmd_valid, i_cmd_write, o_cmd_done, o_cmd_err;
  logic [7:0]  i_cmd_code;
  logic [15:0] i_cmd_wdata, o_cmd_rdata, o_ext_rpt_a, o_ext_rpt_b;
  logic        i_write_protect = 1'b0;
  logic        i_ext_sense_en = 1'b0;
  logic [15:0] i_int_temp = 16'h0190;
  logic [15:0] i_ext_temp_a = 16'h0230;
  logic [15:0] i_ext_temp_b = 16'h00f0;
  logic        o_tc_src_ext, o_dt_hl_frozen, o_dt_lh_frozen;
  logic [23:0] o_rsense_ratio_a, o_rsense_ratio_b;
  logic [9:0]  i_dt_hl_adapt = 10'h000;
  logic [9:0]  i_dt_lh_adapt = 10'h000;
  logic [9:0]  o_dt_hl_ns, o_dt_lh_ns;
  logic [7:0]  o_dt_hl_max, o_dt_lh_max, o_dt_hl_min, o_dt_lh_min;
  int          miscompares = 0;
  int          samples_checked = 0;
  logic [7:0]  codes [5] = '{8'hd9, 8'hda, 8'hdc, 8'hdd, 8'hde};
  logic [15:0] dflt [5] = '{16'hba00, 16'h0000, 16'h0027, 16'h1010, 16'h8888};
  // Scale 2.0, offset +5, tc 5 from external sensors, gaps 60/-15, frozen
  logic [15:0] nv [5] = '{16'h0002, 16'h0005, 16'h0085, 16'h3cf1, 16'h8a86};
  logic [9:0]  ad_in [4] = '{10'h01e, 10'h032, 10'h005, 10'h3ec};
  logic [9:0]  ad_ex [4] = '{10'h01e, 10'h028, 10'h00a, 10'h00a};

  // 100 MHz clock
  always #5 i_sys_clk = ~i_sys_clk;

  tcdt_regbank uut (.i_sys_clk, .i_rst_b, .i_cmd_valid, .i_cmd_write, .i_cmd_code,
    .i_cmd_wdata, .i_write_protect, .o_cmd_done, .o_cmd_err, .o_cmd_rdata,
    .i_ext_sense_en, .i_int_temp, .i_ext_temp_a, .i_ext_temp_b, .o_ext_rpt_a,
    .o_ext_rpt_b, .o_tc_src_ext, .o_rsense_ratio_a, .o_rsense_ratio_b, .i_dt_hl_adapt,
    .i_dt_lh_adapt, .o_dt_hl_ns, .o_dt_lh_ns, .o_dt_hl_frozen, .o_dt_lh_frozen,
    .o_dt_hl_max, .o_dt_lh_max, .o_dt_hl_min, .o_dt_lh_min);

  tcdt_host_model host (.i_sys_clk, .i_cmd_done(o_cmd_done), .i_cmd_err(o_cmd_err),
    .i_cmd_rdata(o_cmd_rdata), .o_cmd_valid(i_cmd_valid), .o_cmd_write(i_cmd_write),
    .o_cmd_code(i_cmd_code), .o_cmd_wdata(i_cmd_wdata));

  task wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Access through the host; a missing answer ends the run
  task acc(input logic wr, input logic [7:0] code, input logic [15:0] wd);
    host.xfer(wr, code, wd);
    if (host.ok !== 1'b1) begin
      miscompares++;
      wrap_up();
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask

  initial begin
    cyc(4);
    i_rst_b = 1'b1;
    // Reset values and derived outputs
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, codes[i], 16'h0000);
      chk(host.rdata, dflt[i]);
    end
    chk({o_dt_hl_ns, o_dt_lh_ns}, 20'h0_4010);
    chk({o_dt_hl_frozen, o_dt_lh_frozen, o_dt_hl_min, o_dt_lh_min}, 18'h3_0808);
    $display("test defaults done");
    // Protected write and unknown command are refused
    i_write_protect = 1'b1;
    acc(1'b1, 8'hdd, 16'h0000);
    chk(host.err, 1'b1);
    acc(1'b0, 8'hdd, 16'h0000);
    chk({host.err, host.rdata}, 17'h0_1010);
    i_write_protect = 1'b0;
    acc(1'b0, 8'hdb, 16'h0000);
    chk({host.err, host.rdata}, 17'h1_0000);
    $display("test refusals done");
    // Successive writes, one idle cycle apart, return the old value; values then mode pairs
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, codes[i], nv[i]);
      chk({host.err, host.rdata}, {1'b0, dflt[i]});
    end
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, codes[i], 16'h0000);
      chk(host.rdata, nv[i]);
    end
    chk({o_dt_hl_max, o_dt_lh_max, o_dt_hl_min, o_dt_lh_min}, 32'h3cf1_0a06);
    chk(o_dt_lh_min, 8'h06);
    chk({o_dt_hl_ns, o_dt_lh_ns}, 20'h0_f3f1);
    $display("test register access done");
    // Stored gaps beyond the supported range are clamped
    acc(1'b1, 8'hdd, 16'hf046);
    cyc(2);
    chk({o_dt_hl_ns, o_dt_lh_ns}, 20'hf_c43c);
    // A read between values and mode breaks the pairing
    acc(1'b0, 8'hdd, 16'h0000);
    acc(1'b1, 8'hde, 16'h0a06);
    chk({o_dt_hl_max, o_dt_lh_max}, 16'h3cf1);
    acc(1'b1, 8'hdd, 16'h2814);
    acc(1'b1, 8'hde, 16'h0a06);
    chk({o_dt_hl_max, o_dt_lh_max}, 16'h2814);
    // Adaptive mode: inside, above max, below min
    for (int i = 0; i < 4; i++) begin
      i_dt_hl_adapt = ad_in[i];
      i_dt_lh_adapt = ad_in[i];
      cyc(2);
      chk(o_dt_hl_ns, ad_ex[i]);
    end
    chk(o_dt_lh_ns, 10'h006);
    $display("test dead time done");
    // Tempco source and correction ratio
    cyc(3);
    chk({o_tc_src_ext, o_rsense_ratio_a}, 25'h0_002710);
    i_ext_sense_en = 1'b1;
    cyc(3);
    chk({o_tc_src_ext, o_rsense_ratio_a}, 25'h1_002742);
    chk(o_rsense_ratio_b, 24'h00_26de);
    acc(1'b1, 8'hdc, 16'h007f);
    cyc(3);
    chk({o_tc_src_ext, o_rsense_ratio_a}, 25'h0_002710);
    acc(1'b1, 8'hdc, 16'h00ff);
    cyc(3);
    chk(o_rsense_ratio_a, 24'h00_2986);
    $display("test tempco done");
    // Reports with scale 2.0 and offset +5, then offset beyond the limit
    cyc(200);
    chk({o_ext_rpt_a, o_ext_rpt_b}, 32'h0168_00c8);
    acc(1'b1, 8'hd9, 16'h0001);
    acc(1'b1, 8'hda, 16'h00c8);
    cyc(200);
    chk(o_ext_rpt_a, 16'h0870);
    // Scale 1.0 written with a negative exponent
    acc(1'b1, 8'hd9, 16'hba00);
    cyc(200);
    chk(o_ext_rpt_b, 16'h0730);
    $display("test reports done");
    wrap_up();
  end
endmodule // tcdt_regbank_bench

bind tcdt_regbank tcdt_regbank_sva chk_u (.i_sys_clk, .i_rst_b, .i_cmd_valid, .i_cmd_write,
  .i_cmd_code, .i_cmd_wdata, .i_write_protect, .o_cmd_done, .o_cmd_err, .i_ext_sense_en,
  .o_tc_src_ext, .i_dt_hl_adapt, .o_dt_hl_ns, .o_dt_lh_ns, .o_dt_hl_frozen,
  .o_dt_lh_frozen, .o_dt_hl_min, .o_dt_hl_max);
